/* File: plc_cmd.v */
// Command interpreter for peer link create, close and write-remote blocks
// ----------------------------------------------------------------------------
// Overview of operation
// R1: Command code 1 starts a new peer protocol instance.
// R2: Host picks an unused connection number 19221 to 19299.
// R3: Protocol manager word must be 36 to select peer protocol.
// R4: Host gives physical port 1 through 4.
// R5: At most four connections, one per physical port.
// R6: Chosen port must already be in host-selected mode.
// R7: Create parameters override switch settings for that port.
// R8: Host requests 7 data bits, odd parity, 1 stop bit.
// R9: Parity 0 none, 1 odd, 2 even; stop bits 1 or 2.
// R10: Baud words 300 to 19200 accepted and applied to port.
// R11: Handshake 0 none, 1 software, 2 hardware, 6 modem RTS/CTS.
// R12: Modem handshake raises RTS to send, waits for CTS.
// R13: Option bit value 0x0001 enables modem control; others zero.
// R14: With modem option, word 11 is modem table address.
// R15: Host clears error word; failures write nonzero error code.
// R16: Later commands with same connection go to that instance.
// R17: Command code 2 closes the named connection.
// R18: Closed instance frees its port and connection number.
// R19: Host writes reserved words as zero.
// R20: Write-remote block has the same layout as task-code master.
// R21: Write-remote command code is 513.
// R22: Write-remote word count lies between 1 and 256.
// R23: Timeout 0 means about 9 s default; above 999 infinite.
// R24: Bad, duplicate, invalid-port or busy create reports an error.
// ----------------------------------------------------------------------------
//
// The implementer's own choices: the plain strobed port and the address map.
`include "plc_map.vh"

module plc_cmd
#(
  parameter NPORT       = 4,
  parameter SEC_CYCLES  = `PLC_CLK_HZ
)
(
  // Clock and reset
  input  wire        CLK_SYS,
  input  wire        RESET,
  // Command block access: word index, data, strobes
  input  wire [3:0]  ADDR,
  input  wire [15:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [15:0] RDATA,
  // Start of command processing, done pulse
  input  wire        START,
  output reg         BUSY,
  output reg         DONE,
  // Host-selected mode per port, from switches
  input  wire [3:0]  PORT_MODE_SEL,
  // Modem lines per port
  input  wire [3:0]  CTS,
  output reg  [3:0]  RTS,
  // Per-port message to send and go permission
  input  wire [3:0]  TX_REQ,
  output reg  [3:0]  TX_GO,
  // Per-port status and configuration
  output reg  [3:0]  PORT_OPEN,
  output reg  [15:0] CFG_BAUD,
  output reg  [15:0] CFG_LINE,
  output reg  [15:0] CFG_MTAB,
  output reg  [1:0]  CFG_PORT,
  output reg         CFG_LOAD,
  // Write-remote request to the instance
  output reg         XFER_REQ,
  output reg  [1:0]  XFER_PORT,
  output reg  [15:0] XFER_SRC,
  output reg  [15:0] XFER_CNT,
  output reg  [15:0] XFER_DST,
  output reg  [31:0] XFER_TMO
);

  // --------------------------------------------------------------------------
  // Command block storage
  // --------------------------------------------------------------------------
  reg [15:0] blk [0:15];
  reg [15:0] conn_tab [0:NPORT-1];
  reg [3:0]  hs_modem;
  wire [3:0] cts_s2;
  wire [3:0] mode_s2;
  reg [15:0] next_err;
  integer    i;
  integer    j;

  wire [15:0] code = blk[`PLC_OFS_CODE];
  wire [15:0] conn = blk[`PLC_OFS_CONN];
  wire [15:0] port = blk[`PLC_OFS_PORT];
  wire [1:0]  pidx = port[1:0] - 2'h1;
  wire [15:0] baud = blk[`PLC_OFS_BAUD];
  wire [15:0] par  = blk[`PLC_OFS_PAR];
  wire [15:0] stp  = blk[`PLC_OFS_STOP];
  wire [15:0] bits = blk[`PLC_OFS_BITS];
  wire [15:0] hs   = blk[`PLC_OFS_HS];
  wire [15:0] opt  = blk[`PLC_OFS_OPT];
  wire [15:0] wcnt = blk[`PLC_OFS_WCNT];
  wire [15:0] tmo  = blk[`PLC_OFS_TMO];

  // --------------------------------------------------------------------------
  // Pin synchronisers: CTS and mode lines come from outside the clock
  // --------------------------------------------------------------------------
  plc_cmd_sync #(.WIDTH(NPORT)) cts_sync_inst
  (
    .clk  (CLK_SYS),
    .rst  (RESET),
    .din  (CTS),
    .dout (cts_s2)
  );

  plc_cmd_sync #(.WIDTH(NPORT)) mode_sync_inst
  (
    .clk  (CLK_SYS),
    .rst  (RESET),
    .din  (PORT_MODE_SEL),
    .dout (mode_s2)
  );

  // --------------------------------------------------------------------------
  // Lookup of connection number among open ports
  // --------------------------------------------------------------------------
  reg       hit;
  reg [1:0] hit_idx;
  always @*
  begin
    hit = 1'b0;
    hit_idx = 2'h0;
    for (i = 0; i < NPORT; i = i + 1)
      if (PORT_OPEN[i] && conn_tab[i] == conn)  // R16
      begin
        hit = 1'b1;
        hit_idx = i[1:0];
      end
  end

  wire conn_ok = conn >= `PLC_CONN_MIN && conn <= `PLC_CONN_MAX;
  wire port_ok = port >= 16'h0001 && port <= 16'h0004;
  wire par_ok  = par == `PLC_PAR_NONE || par == `PLC_PAR_ODD ||
                 par == `PLC_PAR_EVEN;  // R9
  wire stp_ok  = stp == 16'h0001 || stp == 16'h0002;  // R9
  wire bits_ok = bits == 16'h0007 || bits == 16'h0008;
  wire hs_ok   = hs == `PLC_HS_NONE || hs == `PLC_HS_SOFT ||
                 hs == `PLC_HS_HARD || hs == `PLC_HS_MODEM;  // R11
  wire opt_ok  = (opt & ~`PLC_OPT_MODEM) == 16'h0000;  // R13
  wire cnt_ok  = wcnt >= 16'h0001 && wcnt <= `PLC_WCNT_MAX;  // R22

  // Baud words are plain bit rates, 300 up to 19200
  reg        baud_ok;
  always @*
  begin
    case (baud)
      16'h012c,
      16'h0258,
      16'h04b0,
      16'h0960,
      16'h12c0,
      16'h2580,
      16'h4b00:
        baud_ok = 1'b1;  // R10
      default:
        baud_ok = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Command decode: error selection
  // --------------------------------------------------------------------------
  always @*
  begin
    next_err = 16'h0000;
    case (code)
      `PLC_CMD_CREATE:  // R1
      begin
        if (blk[`PLC_OFS_PM] != `PLC_PM_PEER)
          next_err = `PLC_E_PM;  // R3
        else if (!conn_ok)
          next_err = `PLC_E_CONN;  // R24
        else if (hit)
          next_err = `PLC_E_DUP;  // R24
        else if (!port_ok)
          next_err = `PLC_E_PORT;  // R24
        else if (!mode_s2[pidx])
          next_err = `PLC_E_MODE;  // R6
        else if (PORT_OPEN[pidx])
          next_err = `PLC_E_BUSY;  // R5
        else if (!(baud_ok && par_ok && stp_ok && bits_ok && hs_ok &&
                   opt_ok))
          next_err = `PLC_E_PARAM;
      end
      `PLC_CMD_CLOSE:
        if (!hit)
          next_err = `PLC_E_NOCONN;  // R17
      `PLC_CMD_WRITE:  // R21
      begin
        if (!hit)
          next_err = `PLC_E_NOCONN;  // R16
        else if (!cnt_ok)
          next_err = `PLC_E_COUNT;  // R22
      end
      default:
        next_err = `PLC_E_CODE;
    endcase
  end

  // Seconds to cycles; zero marks infinite. At full clock rate 32 bits
  // cannot hold long timeouts, so the count saturates instead of wrapping.
  localparam [31:0] SEC_CYC32 = SEC_CYCLES;
  localparam [31:0] DEF_CYC   = `PLC_TMO_DEF_S * SEC_CYCLES;
  wire [47:0] tmo_full = {32'h00000000, tmo} * {16'h0000, SEC_CYC32};
  wire        tmo_big  = tmo_full[47:32] != 16'h0000;
  wire [31:0] tmo_cyc =
    (tmo == 16'h0000) ? DEF_CYC :  // R23
    (tmo > `PLC_TMO_INF) ? 32'h00000000 :  // R23
    tmo_big ? 32'hffffffff :
    tmo_full[31:0];

  // --------------------------------------------------------------------------
  // Block access, execution and instance table
  // --------------------------------------------------------------------------
  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      for (j = 0; j < 16; j = j + 1)
        blk[j] <= 16'h0000;
      for (j = 0; j < NPORT; j = j + 1)
        conn_tab[j] <= 16'h0000;
      RDATA     <= 16'h0000;
      BUSY      <= 1'b0;
      DONE      <= 1'b0;
      PORT_OPEN <= 4'h0;
      hs_modem  <= 4'h0;
      CFG_BAUD  <= 16'h0000;
      CFG_LINE  <= 16'h0000;
      CFG_MTAB  <= 16'h0000;
      CFG_PORT  <= 2'h0;
      CFG_LOAD  <= 1'b0;
      XFER_REQ  <= 1'b0;
      XFER_PORT <= 2'h0;
      XFER_SRC  <= 16'h0000;
      XFER_CNT  <= 16'h0000;
      XFER_DST  <= 16'h0000;
      XFER_TMO  <= 32'h00000000;
    end
    else
    begin
      DONE     <= 1'b0;
      CFG_LOAD <= 1'b0;
      XFER_REQ <= 1'b0;
      if (RD)
        RDATA <= blk[ADDR];
      // Host writes ignored while a command executes
      if (WR && !BUSY)
        blk[ADDR] <= WDATA;
      if (START && !BUSY)
        BUSY <= 1'b1;
      else if (BUSY)
      begin
        BUSY <= 1'b0;
        DONE <= 1'b1;
        if (next_err != 16'h0000)
          blk[`PLC_OFS_ERR] <= next_err;  // R15
        else
          case (code)
            `PLC_CMD_CREATE:
            begin
              PORT_OPEN[pidx] <= 1'b1;
              conn_tab[pidx]  <= conn;  // R16
              hs_modem[pidx]  <= hs == `PLC_HS_MODEM;  // R12
              CFG_PORT <= pidx;
              CFG_BAUD <= baud;  // R7
              CFG_LINE <= {hs[3:0], opt[0], stp[1:0], par[1:0],
                           bits[3:0], 3'h0};  // R7
              CFG_MTAB <= opt[0] ? blk[`PLC_OFS_MTAB] : 16'h0000;  // R14
              CFG_LOAD <= 1'b1;
            end
            `PLC_CMD_CLOSE:
            begin
              PORT_OPEN[hit_idx] <= 1'b0;  // R18
              conn_tab[hit_idx]  <= 16'h0000;  // R18
              hs_modem[hit_idx]  <= 1'b0;
            end
            default:
            begin
              XFER_REQ  <= 1'b1;  // R20
              XFER_PORT <= hit_idx;
              XFER_SRC  <= blk[`PLC_OFS_SRC];
              XFER_CNT  <= wcnt;
              XFER_DST  <= blk[`PLC_OFS_DST];
              XFER_TMO  <= tmo_cyc;
            end
          endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Modem handshake per port
  // --------------------------------------------------------------------------
  always @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      RTS     <= 4'h0;
      TX_GO   <= 4'h0;
    end
    else
    begin
      RTS   <= PORT_OPEN & hs_modem & TX_REQ;  // R12
      // Without modem handshake sending is not held back
      TX_GO <= PORT_OPEN & TX_REQ & (~hs_modem | cts_s2);  // R12
    end
  end

endmodule // plc_cmd

// ----------------------------------------------------------------------------
// Two-flop synchroniser for pins from outside the clock domain
// ----------------------------------------------------------------------------
module plc_cmd_sync
#(
  parameter WIDTH = 4
)
(
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  // Pin side and clock side
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  // First stage may be metastable; only the second stage reads it
  reg [WIDTH-1:0] meta;

  always @(posedge clk)
  begin
    if (rst)
    begin
      meta <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // plc_cmd_sync

/* File: plc_cmd_monitor.sv */
// Port checker for the peer link command interpreter
module plc_cmd_monitor (
  // Clock, reset and strobes
  input wire logic        CLK_SYS, RESET, RD, START, BUSY, DONE,
  // Modem and send lines
  input wire logic [3:0]  CTS, RTS, TX_REQ, TX_GO, PORT_OPEN,
  // Results
  input wire logic        CFG_LOAD, XFER_REQ,
  input wire logic [15:0] RDATA, XFER_CNT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  busy_after_start_a: assert property (START && !BUSY |=> BUSY)
    else $error("busy missing after start");
  done_after_busy_a: assert property (BUSY |=> DONE && !BUSY)
    else $error("done missing after busy");
  done_single_a: assert property (DONE |=> !DONE)
    else $error("done longer than one cycle");
  cfg_with_done_a: assert property (CFG_LOAD |-> DONE)
    else $error("config load outside done");
  xfer_count_ok_a: assert property
    (XFER_REQ |-> DONE && XFER_CNT inside {[1:256]})
    else $error("transfer count out of range");
  open_on_done_a: assert property ($changed(PORT_OPEN) |-> DONE)
    else $error("port open changed outside done");
  rts_needs_req_a: assert property ((RTS & ~$past(TX_REQ)) == 4'h0)
    else $error("rts without message");
  go_waits_cts_a: assert property
    ((TX_GO & RTS & ~$past(CTS, 3)) == 4'h0)
    else $error("send granted before cts");
  rdata_holds_a: assert property (!$past(RD) |-> $stable(RDATA))
    else $error("read data moved without read");
  cover property (CFG_LOAD);
  cover property (XFER_REQ);
  cover property (|(TX_GO & RTS));
endmodule // plc_cmd_monitor
bind plc_cmd plc_cmd_monitor plc_cmd_monitor_inst (.CLK_SYS(CLK_SYS),
  .RESET(RESET), .RD(RD), .START(START), .BUSY(BUSY), .DONE(DONE),
  .CTS(CTS), .RTS(RTS), .TX_REQ(TX_REQ), .TX_GO(TX_GO),
  .PORT_OPEN(PORT_OPEN), .CFG_LOAD(CFG_LOAD), .XFER_REQ(XFER_REQ),
  .RDATA(RDATA), .XFER_CNT(XFER_CNT));

/* File: plc_map.vh */
// Command block word offsets, codes, limits and timing for the command engine
`ifndef PLC_MAP_VH
`define PLC_MAP_VH
// ----------------------------------------------------------------------------
// Command block word offsets
// ----------------------------------------------------------------------------
`define PLC_OFS_ERR      4'h0
`define PLC_OFS_CODE     4'h1
`define PLC_OFS_CONN     4'h2
`define PLC_OFS_PM       4'h3
`define PLC_OFS_PORT     4'h4
`define PLC_OFS_BAUD     4'h5
`define PLC_OFS_BITS     4'h6
`define PLC_OFS_PAR      4'h7
`define PLC_OFS_STOP     4'h8
`define PLC_OFS_HS       4'h9
`define PLC_OFS_OPT      4'ha
`define PLC_OFS_MTAB     4'hb
`define PLC_OFS_WCNT     4'h4
`define PLC_OFS_TMO      4'h6
`define PLC_OFS_SRC      4'h3
`define PLC_OFS_DST      4'h5
// ----------------------------------------------------------------------------
// Command codes and values
// ----------------------------------------------------------------------------
`define PLC_CMD_CREATE   16'h0001
`define PLC_CMD_CLOSE    16'h0002
`define PLC_CMD_WRITE    16'h0201
`define PLC_PM_PEER      16'h0024
`define PLC_CONN_MIN     16'h4b15
`define PLC_CONN_MAX     16'h4b63
`define PLC_WCNT_MAX     16'h0100
`define PLC_TMO_INF      16'h03e7
`define PLC_OPT_MODEM    16'h0001
`define PLC_HS_NONE      16'h0000
`define PLC_HS_SOFT      16'h0001
`define PLC_HS_HARD      16'h0002
`define PLC_HS_MODEM     16'h0006
`define PLC_PAR_NONE     16'h0000
`define PLC_PAR_ODD      16'h0001
`define PLC_PAR_EVEN     16'h0002
// ----------------------------------------------------------------------------
// Error codes (nonzero)
// ----------------------------------------------------------------------------
`define PLC_E_CODE       16'h0001
`define PLC_E_CONN       16'h0002
`define PLC_E_DUP        16'h0003
`define PLC_E_PORT       16'h0004
`define PLC_E_BUSY       16'h0005
`define PLC_E_PARAM      16'h0006
`define PLC_E_NOCONN     16'h0007
`define PLC_E_PM         16'h0008
`define PLC_E_COUNT      16'h0009
`define PLC_E_MODE       16'h000a
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PLC_CLK_HZ       100000000
`define PLC_TMO_DEF_S    9
`endif

/* File: plc_peer_model.sv */
// Behavioural far side: message source and modem answering RTS
module plc_peer_model (
  input  wire logic [3:0] rts, go, load, dly,
  input  wire logic       clk,
  output logic      [3:0] req, cts
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt [4] = '{default: 4'h0};
  initial req = 4'h0;
  initial cts = 4'h0;
  always @(posedge clk)
    for (int i = 0; i < 4; i++)
    begin
      // Message stays pending until the send is granted
      if (load[i]) req[i] <= 1'b1;
      else if (go[i]) req[i] <= 1'b0;
      // Slow modem, delay varies per message
      if (!rts[i]) cnt[i] <= 4'h0;
      else if (cnt[i] < dly) cnt[i] <= cnt[i] + 4'h1;
      cts[i] <= rts[i] && cnt[i] >= dly;
    end
endmodule // plc_peer_model

/* File: tb.sv */
// Random self-checking bench for the peer link command interpreter
`include "plc_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SEC = 10;
  logic        CLK_SYS = 0, RESET = 1, WR = 0, RD = 0, START = 0;
  logic [3:0]  ADDR = 0, PORT_MODE_SEL = 4'hd, load = 0, dly = 0;
  logic [15:0] WDATA = 0, rdv, blk [16], conn_of [4] = '{default: 0};
  wire  [15:0] RDATA, CFG_BAUD, CFG_LINE, CFG_MTAB, XFER_SRC, XFER_CNT;
  wire  [15:0] XFER_DST;
  wire  [31:0] XFER_TMO;
  wire  [3:0]  CTS, RTS, TX_REQ, TX_GO, PORT_OPEN;
  wire  [1:0]  CFG_PORT, XFER_PORT;
  wire         BUSY, DONE, CFG_LOAD, XFER_REQ;
  int          mismatches = 0, comparisons = 0;
  logic [31:0] seed = 32'd44711;
  logic [15:0] baud_tab [8] = '{16'h012c, 16'h0258, 16'h04b0, 16'h0960,
                                16'h12c0, 16'h2580, 16'h4b00, 16'h03e8};
  logic [15:0] hs_tab [4] = '{16'h0, 16'h1, 16'h2, 16'h6};
  logic [15:0] tmo_tab [4] = '{16'h0, 16'h03e7, 16'h03e8, 16'h5};
  always #5 CLK_SYS = ~CLK_SYS;
  plc_cmd #(.SEC_CYCLES(SEC)) plc_cmd_inst (.CLK_SYS(CLK_SYS),
    .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .START(START), .BUSY(BUSY), .DONE(DONE),
    .PORT_MODE_SEL(PORT_MODE_SEL), .CTS(CTS), .RTS(RTS), .TX_REQ(TX_REQ),
    .TX_GO(TX_GO), .PORT_OPEN(PORT_OPEN), .CFG_BAUD(CFG_BAUD),
    .CFG_LINE(CFG_LINE), .CFG_MTAB(CFG_MTAB), .CFG_PORT(CFG_PORT),
    .CFG_LOAD(CFG_LOAD), .XFER_REQ(XFER_REQ), .XFER_PORT(XFER_PORT),
    .XFER_SRC(XFER_SRC), .XFER_CNT(XFER_CNT), .XFER_DST(XFER_DST),
    .XFER_TMO(XFER_TMO));
  plc_peer_model plc_peer_model_inst (.clk(CLK_SYS), .rts(RTS),
    .go(TX_GO), .load(load), .dly(dly), .req(TX_REQ), .cts(CTS));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int port_of(logic [15:0] c);
    for (int i = 0; i < 4; i++) if (conn_of[i] === c) return i;
    return -1;
  endfunction
  function automatic logic [15:0] exp_create();
    if (blk[3] != `PLC_PM_PEER) return `PLC_E_PM;
    if (blk[2] < `PLC_CONN_MIN || blk[2] > `PLC_CONN_MAX)
      return `PLC_E_CONN;
    if (port_of(blk[2]) >= 0) return `PLC_E_DUP;
    if (blk[4] < 1 || blk[4] > 4) return `PLC_E_PORT;
    if (!PORT_MODE_SEL[blk[4] - 1]) return `PLC_E_MODE;
    if (conn_of[blk[4] - 1] != 0) return `PLC_E_BUSY;
    if (blk[7] > 2 || blk[5] == baud_tab[7] || blk[9] == 3 || blk[10] > 1)
      return `PLC_E_PARAM;
    return 16'h0;
  endfunction
  task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic issue();
    for (int i = 0; i < 16; i++)
    begin
      @(posedge CLK_SYS);
      ADDR <= 4'(i);
      WDATA <= blk[i];
      WR <= 1;
    end
    @(posedge CLK_SYS);
    WR <= 0;
    START <= 1;
    @(posedge CLK_SYS);
    START <= 0;
    for (int k = 0; k < 6 && DONE !== 1'b1; k++) @(posedge CLK_SYS) #1;
    chk("done", DONE, 1);
  endtask
  task automatic conclude();
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    mismatches++;
    conclude();
  end
  initial
  begin
    logic [31:0] r;
    logic [15:0] e;
    logic [3:0]  m;
    int          p;
    repeat (6) @(posedge CLK_SYS);
    RESET <= 0;
    for (int n = 0; n < 90; n++)
    begin
      r = rnd();
      // Mode inputs pass a synchroniser, so let them settle
      @(posedge CLK_SYS);
      if (n % 16 == 0) PORT_MODE_SEL <= r[3:0] | 4'h1;
      load <= r[7:4];
      dly <= r[11:8];
      repeat (4) @(posedge CLK_SYS);
      load <= 4'h0;
      r = rnd();
      blk = '{default: 16'h0};
      blk[2] = r[5:3] == 0 ? `PLC_CONN_MAX + 16'h1 : r[5:3] == 1 ?
               `PLC_CONN_MAX : `PLC_CONN_MIN - 16'h1 + r[2:0];
      blk[1] = r[9:8] == 2 ? `PLC_CMD_CLOSE : r[9:8] < 2 ? `PLC_CMD_CREATE
               : r[10] ? `PLC_CMD_WRITE : 16'h0003;
      p = port_of(blk[2]);
      e = p < 0 ? `PLC_E_NOCONN : 16'h0;
      if (blk[1] == `PLC_CMD_CREATE)
      begin
        blk[3] = r[12:11] == 0 ? 16'h0023 : `PLC_PM_PEER;
        blk[4] = r[15:13];
        blk[5] = baud_tab[r[18:16]];
        blk[6] = 16'h7;
        blk[7] = r[20:19];
        blk[8] = 16'h1 + r[21];
        blk[9] = r[25:24] == 3 ? 16'h3 : hs_tab[r[23:22]];
        blk[10] = r[27:26] == 3 ? 16'h2 : r[26];
        blk[11] = {r[31:28], r[11:0]};
        e = exp_create();
      end
      if (blk[1] == `PLC_CMD_WRITE)
      begin
        blk[3] = r[31:16];
        blk[5] = ~r[31:16];
        blk[4] = r[12:11] == 0 ? (r[13] ? 16'h0 : 16'h101) : r[12:11] == 1
                 ? 16'h1 : r[12:11] == 2 ? 16'h100 : r[21:14] + 16'h1;
        if (p < 0) blk[4] = 16'h1;
        blk[6] = tmo_tab[r[23:22]];
        if (p >= 0 && (blk[4] < 1 || blk[4] > 256)) e = `PLC_E_COUNT;
      end
      if (blk[1] == 16'h0003) e = `PLC_E_CODE;
      issue();
      if (blk[1] == `PLC_CMD_CREATE)
      begin
        chk("cfg_load", CFG_LOAD, e == 0);
        if (e == 0)
        begin
          chk("cfg_port", CFG_PORT, blk[4] - 1);
          chk("cfg_baud", CFG_BAUD, blk[5]);
          chk("cfg_line", CFG_LINE, {blk[9][3:0], blk[10][0], blk[8][1:0],
              blk[7][1:0], blk[6][3:0], 3'h0});
          chk("cfg_mtab", CFG_MTAB, blk[10][0] ? blk[11] : 16'h0);
          conn_of[blk[4] - 1] = blk[2];
        end
      end
      if (blk[1] == `PLC_CMD_CLOSE && e == 0) conn_of[p] = 16'h0;
      if (blk[1] == `PLC_CMD_WRITE)
      begin
        chk("xfer_req", XFER_REQ, e == 0);
        if (e == 0)
        begin
          chk("xfer_port", XFER_PORT, p);
          chk("xfer_words", {XFER_SRC, XFER_CNT, XFER_DST},
              {blk[3], blk[4], blk[5]});
          chk("xfer_tmo", XFER_TMO, blk[6] == 0 ? `PLC_TMO_DEF_S * SEC :
              blk[6] > `PLC_TMO_INF ? 32'h0 : blk[6] * SEC);
        end
      end
      for (int i = 0; i < 4; i++) m[i] = conn_of[i] != 0;
      chk("port_open", PORT_OPEN, m);
      @(posedge CLK_SYS);
      ADDR <= 4'h0;
      RD <= 1;
      @(posedge CLK_SYS);
      RD <= 0;
      #1 rdv = RDATA;
      chk("error_word", rdv, e);
    end
    conclude();
  end
endmodule // tb
